// ### src/fsf_pkg.sv
/*
 * Package for the flash status and error-flag register bank.
 * Assumes a 32-bit AHB-Lite register bus, one aligned word per register.
 */
package fsf_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] FSF_STATUS_OFS     = 8'h00;
    localparam logic [7:0] FSF_ERROR_OFS      = 8'h04;
    localparam logic [7:0] FSF_CTRL_OFS       = 8'h08;
    ////////////////////////////////////////////////////////////////////////////
    // Status register fields
    localparam int         FSF_CMD_DONE_BIT   = 7;
    localparam int         FSF_ACC_ERR_BIT    = 5;
    localparam int         FSF_PROT_VIOL_BIT  = 4;
    localparam int         FSF_BUSY_BIT       = 3;
    localparam int         FSF_RSVD_BIT       = 2;
    localparam int         FSF_CERR_LSB       = 0;
    localparam int         FSF_CERR_W         = 2;
    ////////////////////////////////////////////////////////////////////////////
    // Error status register fields
    localparam int         FSF_DFAULT_BIT     = 1;
    localparam int         FSF_SFAULT_BIT     = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int         FSF_CDIE_BIT       = 7;
    localparam int         FSF_IGNORE_SINGLE_FAULT_BIT      = 4;
    localparam int         FSF_SFIE_BIT       = 0;
    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] FSF_STATUS_RST     = 8'h80;
    localparam logic [7:0] FSF_ERROR_RST      = 8'h00;
    localparam logic [7:0] FSF_CTRL_RST       = 8'h00;
    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite encodings
    localparam logic [1:0] FSF_HTRANS_NONSEQ  = 2'h2;
    localparam logic [1:0] FSF_HTRANS_SEQ     = 2'h3;
    localparam logic [2:0] FSF_HSIZE_WORD     = 3'h2;
endpackage

// ### src/fsf_regs.sv
/*
 * Flash status and error-flag register bank with an AHB-Lite slave.
 * Assumes the command sequencer, the protection logic and the array read
 * path sit outside and talk to this bank through one-cycle event pulses on
 * mclk. The reset sequence reports its end through rst_seq_done and its outcome through rst_seq_error and rst_seq_dfault.
 */
// Overview of operation
// RQ1: Writing one to command-done launches a command and clears the flag; zero does nothing.
// RQ2: After launch, command-done stays zero until completion or command violation.
// RQ3: Broken write sequence or illegal command sets the access-error flag.
// RQ4: While access-error is set, writing one to command-done neither clears nor launches.
// RQ5: Access-error clears only on a write of one to its bit.
// RQ6: Program or erase of a protected region sets the protection-violation flag.
// RQ7: Protection-violation clears only on a write of one to its bit.
// RQ8: While protection-violation is set, no launch and no new write sequence start.
// RQ9: Busy bit is one while a command executes, zero when idle.
// RQ10: Status bit 2 is reserved and always reads zero.
// RQ11: Errors during a command or the reset sequence set the completion error field.
// RQ12: Completion error field clears when a new command starts executing.
// RQ13: Only command-done, access-error, protection-violation are writable in status.
// RQ14: Double-bit read error, or invalid read of a busy block, sets double-fault.
// RQ15: Double-fault clears only on a write of one to its bit.
// RQ16: With ignore-single-fault clear, corrected or invalid reads set single-fault.
// RQ17: Single-fault clears only on a write of one to its bit.
// RQ18: New ECC errors are recorded reliably only when the fault flags are clear.
// RQ19: ECC fault flags are stored one cycle after the array read.
// RQ20: A double fault during reset sequence may leave status off its reset value.
// RQ21: Command-done interrupt request while its enable and the flag are one.
// RQ22: Single-fault interrupt request while its enable and the flag are one.
// RQ23: After a clean reset, command-done reads one and busy and errors zero.
module fsf_regs
    import fsf_pkg::*;
#(
    parameter int CERR_W = FSF_CERR_W
)
(
    input  wire logic                mclk,
    input  wire logic                nrst,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [7:0]          haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic                hready,
    input  wire logic [31:0]         hwdata,
    output logic      [31:0]         hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Command sequencer side
    input  wire logic                seq_break,
    input  wire logic                illegal_cmd,
    input  wire logic                prot_hit,
    input  wire logic                cmd_start,
    input  wire logic                cmd_complete,
    input  wire logic                cmd_violation,
    input  wire logic [CERR_W-1:0]   cmd_error,
    input  wire logic                rst_seq_done,
    input  wire logic [CERR_W-1:0]   rst_seq_error,
    input  wire logic                rst_seq_dfault,
    output logic                     cmd_launch,
    output logic                     seq_start_allow,
    // Array read path
    input  wire logic                rd_valid,
    input  wire logic                rd_dbl_fault,
    input  wire logic                rd_sgl_fault,
    input  wire logic                rd_invalid_busy,
    // Status towards the system
    output logic                     ignore_single_fault,
    output logic                     cmd_done_irq,
    output logic                     single_fault_irq
);
    import fsf_pkg::*;

    // Completion field must fit below the reserved status bit
    if (CERR_W < 1 || CERR_W > FSF_RSVD_BIT - FSF_CERR_LSB) begin : g_bad_cerr_w
        $error("fsf_regs: CERR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus address phase capture
    logic       dp_valid_r;
    logic       dp_write_r;
    logic [7:0] dp_addr_r;
    logic       addr_ok;
    logic       size_ok;

    function automatic logic fsf_hit(input logic [7:0] a, input logic [7:0] ofs);
        fsf_hit = (a == ofs);
    endfunction

    assign addr_ok = hsel && hready && htrans[1];
    // Transfers wider than the data bus write nothing
    assign size_ok = (hsize <= FSF_HSIZE_WORD);

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dp_valid_r <= 1'b0;
            dp_write_r <= 1'b0;
            dp_addr_r  <= 8'h00;
        end else if (hready) begin
            dp_valid_r <= addr_ok && size_ok;
            dp_write_r <= hwrite;
            dp_addr_r  <= haddr;
        end
    end

    // Read address phase meeting a write data phase waits one cycle,
    // else it would return the value from before that write
    logic raw_hit;
    logic raw_wait_r;

    assign raw_hit = addr_ok && !hwrite && dp_valid_r && dp_write_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            raw_wait_r <= 1'b0;
        end else begin
            raw_wait_r <= raw_hit;
        end
    end

    // Otherwise zero wait states, always OKAY
    assign hreadyout = !raw_wait_r;
    assign hresp     = 1'b0;

    logic       wr_status;
    logic       wr_error;
    logic       wr_ctrl;
    assign wr_status = dp_valid_r && dp_write_r && fsf_hit(dp_addr_r, FSF_STATUS_OFS);
    assign wr_error  = dp_valid_r && dp_write_r && fsf_hit(dp_addr_r, FSF_ERROR_OFS);
    assign wr_ctrl   = dp_valid_r && dp_write_r && fsf_hit(dp_addr_r, FSF_CTRL_OFS);

    ////////////////////////////////////////////////////////////////////////////
    // Status flags
    logic                  cmd_done_r;
    logic                  acc_err_r;
    logic                  prot_viol_r;
    logic                  busy_r;
    logic [CERR_W-1:0]     cerr_r;
    logic                  init_done_r;
    logic                  launch_req;
    logic                  acc_err_set;
    logic                  prot_viol_set;

    // Launch only from a one on command-done with both error flags clear
    assign launch_req = wr_status && hwdata[FSF_CMD_DONE_BIT] && cmd_done_r
                        && !acc_err_r && !prot_viol_r && init_done_r; // RQ1 RQ4 RQ8
    assign cmd_launch      = launch_req;
    assign seq_start_allow = cmd_done_r && !prot_viol_r && init_done_r; // RQ8

    assign acc_err_set   = seq_break || illegal_cmd; // RQ3
    assign prot_viol_set = prot_hit; // RQ6

    // Command-done held low during the reset sequence, then released
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_done_r <= 1'b0;
        end else if (rst_seq_done && !init_done_r) begin
            cmd_done_r <= 1'b1; // RQ23
        end else if (launch_req) begin
            cmd_done_r <= 1'b0; // RQ1
        end else if (cmd_complete || cmd_violation) begin
            cmd_done_r <= 1'b1; // RQ2
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            init_done_r <= 1'b0;
        end else if (rst_seq_done) begin
            init_done_r <= 1'b1;
        end
    end

    // Set wins over a simultaneous write-one clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_err_r <= 1'b0;
        end else if (acc_err_set) begin
            acc_err_r <= 1'b1; // RQ3
        end else if (wr_status && hwdata[FSF_ACC_ERR_BIT]) begin
            acc_err_r <= 1'b0; // RQ5
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prot_viol_r <= 1'b0;
        end else if (prot_viol_set) begin
            prot_viol_r <= 1'b1; // RQ6
        end else if (wr_status && hwdata[FSF_PROT_VIOL_BIT]) begin
            prot_viol_r <= 1'b0; // RQ7
        end
    end

    // Busy spans from start of execution to completion or violation
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
        end else if (cmd_complete || cmd_violation) begin
            busy_r <= 1'b0; // RQ9
        end else if (cmd_start && !cmd_done_r) begin
            busy_r <= 1'b1; // RQ9
        end
    end

    // Error bits accumulate; a new start wipes old ones first
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cerr_r <= '0;
        end else if (rst_seq_done && !init_done_r) begin
            cerr_r <= rst_seq_error; // RQ11 RQ20
        end else if (cmd_start && !cmd_done_r) begin
            cerr_r <= cmd_error; // RQ12
        end else if (busy_r) begin
            cerr_r <= cerr_r | cmd_error; // RQ11
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register: interrupt enables and ignore-single-fault
    logic cdie_r;
    logic sfie_r;
    logic ignore_single_fault_r;

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cdie_r  <= FSF_CTRL_RST[FSF_CDIE_BIT];
            sfie_r  <= FSF_CTRL_RST[FSF_SFIE_BIT];
            ignore_single_fault_r <= FSF_CTRL_RST[FSF_IGNORE_SINGLE_FAULT_BIT];
        end else if (wr_ctrl) begin
            cdie_r  <= hwdata[FSF_CDIE_BIT];
            sfie_r  <= hwdata[FSF_SFIE_BIT];
            ignore_single_fault_r <= hwdata[FSF_IGNORE_SINGLE_FAULT_BIT];
        end
    end
    assign ignore_single_fault = ignore_single_fault_r;

    ////////////////////////////////////////////////////////////////////////////
    // ECC fault flags, stored one cycle after the read result
    logic dfault_r;
    logic sfault_r;
    logic dfault_ev;
    logic sfault_ev;

    assign dfault_ev = (rd_valid && (rd_dbl_fault || rd_invalid_busy))
                       || (rst_seq_dfault && !init_done_r); // RQ14 RQ20
    assign sfault_ev = rd_valid && !ignore_single_fault_r && (rd_sgl_fault || rd_invalid_busy); // RQ16

    // A new error is only taken when the flag is already clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dfault_r <= FSF_ERROR_RST[FSF_DFAULT_BIT];
        end else if (dfault_ev && !dfault_r) begin
            dfault_r <= 1'b1; // RQ14 RQ18 RQ19
        end else if (wr_error && hwdata[FSF_DFAULT_BIT] && !dfault_ev) begin
            dfault_r <= 1'b0; // RQ15
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sfault_r <= FSF_ERROR_RST[FSF_SFAULT_BIT];
        end else if (sfault_ev && !sfault_r) begin
            sfault_r <= 1'b1; // RQ16 RQ18 RQ19
        end else if (wr_error && hwdata[FSF_SFAULT_BIT] && !sfault_ev) begin
            sfault_r <= 1'b0; // RQ17
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt requests, registered
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_done_irq     <= 1'b0;
            single_fault_irq <= 1'b0;
        end else begin
            cmd_done_irq     <= cdie_r && cmd_done_r; // RQ21
            single_fault_irq <= sfie_r && sfault_r; // RQ22
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    logic [7:0] status_val;
    logic [7:0] error_val;
    logic [7:0] ctrl_val;
    logic [7:0] rd_mux;
    logic [7:0] rd_wait_mux;

    always_comb begin
        status_val                       = 8'h00; // RQ10 RQ13
        status_val[FSF_CMD_DONE_BIT]     = cmd_done_r;
        status_val[FSF_ACC_ERR_BIT]      = acc_err_r;
        status_val[FSF_PROT_VIOL_BIT]    = prot_viol_r;
        status_val[FSF_BUSY_BIT]         = busy_r;
        status_val[FSF_CERR_LSB +: CERR_W] = cerr_r;
        error_val                        = 8'h00;
        error_val[FSF_DFAULT_BIT]        = dfault_r;
        error_val[FSF_SFAULT_BIT]        = sfault_r;
        ctrl_val                         = 8'h00;
        ctrl_val[FSF_CDIE_BIT]           = cdie_r;
        ctrl_val[FSF_IGNORE_SINGLE_FAULT_BIT]          = ignore_single_fault_r;
        ctrl_val[FSF_SFIE_BIT]           = sfie_r;
    end

    function automatic logic [7:0] fsf_read(input logic [7:0] a,
                                             input logic [7:0] st,
                                             input logic [7:0] er,
                                             input logic [7:0] ct);
        case (a)
            FSF_STATUS_OFS: fsf_read = st;
            FSF_ERROR_OFS:  fsf_read = er;
            FSF_CTRL_OFS:   fsf_read = ct;
            default:        fsf_read = 8'h00;
        endcase
    endfunction

    // Address phase value, and the value for a read held by a wait state
    assign rd_mux      = fsf_read(haddr, status_val, error_val, ctrl_val);
    assign rd_wait_mux = fsf_read(dp_addr_r, status_val, error_val, ctrl_val);

    // Read data registered at the address phase; unmapped reads zero
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            hrdata <= 32'h0000_0000;
        end else if (raw_wait_r) begin
            hrdata <= {24'h00_0000, rd_wait_mux};
        end else if (addr_ok && !hwrite) begin
            hrdata <= {24'h00_0000, rd_mux};
        end
    end
endmodule

// ### verif/fsf_checker.sv
/* Checker for the flash status register bank, watching top-level ports only.
   Assumes AHB-Lite with hreadyout fed back as hready. */
module fsf_checker (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        seq_break,
    input wire logic        illegal_cmd,
    input wire logic        prot_hit,
    input wire logic        cmd_complete,
    input wire logic        cmd_violation,
    input wire logic        cmd_launch,
    input wire logic        seq_start_allow,
    input wire logic        ignore_single_fault,
    input wire logic        cmd_done_irq,
    input wire logic        single_fault_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    import fsf_pkg::*;
    ////////////////////////////////////////////////////////////////////////////
    logic       dp_v_r;
    logic       dp_wr_r;
    logic [7:0] dp_addr_r;
    logic       acc_r;
    logic       prot_r;
    logic       wait_r;
    wire logic  st_wr = dp_v_r && dp_wr_r && dp_addr_r == FSF_STATUS_OFS;
    wire logic  st_rd = dp_v_r && !dp_wr_r && dp_addr_r == FSF_STATUS_OFS;
    wire logic  ct_wr = dp_v_r && dp_wr_r && dp_addr_r == FSF_CTRL_OFS;
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dp_v_r    <= 1'b0;
            dp_wr_r   <= 1'b0;
            dp_addr_r <= 8'h00;
        end else if (hready) begin
            dp_v_r    <= hsel && htrans[1];
            dp_wr_r   <= hwrite;
            dp_addr_r <= haddr;
        end
    end
    // Shadow flags; a set wins over a write-one clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            acc_r  <= 1'b0;
            prot_r <= 1'b0;
            wait_r <= 1'b0;
        end else begin
            acc_r  <= seq_break || illegal_cmd || (acc_r && !(st_wr && hwdata[FSF_ACC_ERR_BIT]));
            prot_r <= prot_hit || (prot_r && !(st_wr && hwdata[FSF_PROT_VIOL_BIT]));
            wait_r <= cmd_launch || (wait_r && !cmd_complete && !cmd_violation);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_launch_on_one: assert property (cmd_launch |-> st_wr && hwdata[7] && seq_start_allow)
        else $error("launch without an allowed write of one");
    a_done_held_low: assert property (wait_r |-> !seq_start_allow)
        else $error("command-done back before completion");
    a_done_returns: assert property (wait_r && cmd_complete && !prot_r && !prot_hit
        |=> seq_start_allow)
        else $error("command-done not set on completion");
    a_prot_hit_sets: assert property (prot_hit |=> !seq_start_allow)
        else $error("protection hit did not block");
    a_acc_blocks: assert property (acc_r |-> !cmd_launch)
        else $error("launch while access error set");
    a_prot_blocks: assert property (prot_r |-> !seq_start_allow && !cmd_launch)
        else $error("start allowed while violation set");
    a_rsvd_zero: assert property (st_rd |-> !hrdata[FSF_RSVD_BIT] && hrdata[31:8] == 24'h0)
        else $error("reserved status bits read nonzero");
    a_ignore_follows: assert property (ct_wr |=> ignore_single_fault == $past(hwdata[4]))
        else $error("ignore single fault not written");
    c_launch: cover property (cmd_launch);
    c_prot: cover property (prot_hit ##1 prot_r);
    c_sf_irq: cover property ($rose(single_fault_irq));
    c_cd_irq: cover property ($rose(cmd_done_irq));
endmodule

bind fsf_regs fsf_checker u_chk (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hready,
    .hwdata, .hrdata, .seq_break, .illegal_cmd, .prot_hit, .cmd_complete, .cmd_violation,
    .cmd_launch, .seq_start_allow, .ignore_single_fault, .cmd_done_irq, .single_fault_irq);

// ### verif/fsf_regs_tb_top.sv
/* Self-checking bench for fsf_regs: AHB-Lite tasks and event pulses.
   Assumes one clock and that hreadyout alone forms the bus hready. */
module fsf_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fsf_pkg::*;
    logic        mclk, nrst, hsel, hwrite, hreadyout, hresp, seq_break, illegal_cmd;
    logic        prot_hit, cmd_start, cmd_complete, cmd_violation, rst_seq_done;
    logic        rst_seq_dfault, cmd_launch, seq_start_allow, rd_valid, rd_dbl_fault;
    logic        rd_sgl_fault, rd_invalid_busy, ignore_single_fault, cmd_done_irq;
    logic        single_fault_irq, launched;
    logic [1:0]  htrans, cmd_error, rst_seq_error;
    logic [2:0]  hsize;
    logic [2:0]  fq [3] = '{3'h4, 3'h2, 3'h1};
    logic [7:0]  haddr;
    logic [7:0]  fx [3] = '{8'h02, 8'h01, 8'h03};
    logic [31:0] hwdata, hrdata, rdat;
    int          num_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;
    fsf_regs DUT (.mclk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
        .hwdata, .hrdata, .hreadyout, .hresp, .seq_break, .illegal_cmd, .prot_hit, .cmd_start,
        .cmd_complete, .cmd_violation, .cmd_error, .rst_seq_done, .rst_seq_error,
        .rst_seq_dfault, .cmd_launch, .seq_start_allow, .rd_valid, .rd_dbl_fault,
        .rd_sgl_fault, .rd_invalid_busy, .ignore_single_fault, .cmd_done_irq,
        .single_fault_irq);
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            summarize();
        end
    end
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Entered just after a rising edge; rdat taken at the closing edge
    task automatic ahb(logic wr, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= FSF_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= FSF_HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        #1 launched = cmd_launch;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        ahb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd_chk(string what, logic [7:0] a, logic [7:0] exp);
        ahb(1'b0, a, 32'h0);
        check(what, rdat, {24'h0, exp});
        check("hresp", 32'(hresp), 32'h0);
    endtask
    // Mask order: break, illegal, prot, start, complete, violation, init, read
    task automatic ev(logic [7:0] m);
        {seq_break, illegal_cmd, prot_hit, cmd_start, cmd_complete, cmd_violation,
            rst_seq_done, rd_valid} <= m;
        @(posedge mclk);
        {seq_break, illegal_cmd, prot_hit, cmd_start, cmd_complete, cmd_violation,
            rst_seq_done, rd_valid} <= 8'h00;
        @(posedge mclk);
    endtask
    task automatic boot(logic [1:0] e, logic df);
        nrst <= 1'b0;
        rst_seq_error <= e;
        rst_seq_dfault <= df;
        repeat (4) @(posedge mclk);
        nrst <= 1'b1;
        @(posedge mclk);
        rd_chk("status", FSF_STATUS_OFS, 8'h00);
        ev(8'h02);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {nrst, hsel, hwrite, seq_break, illegal_cmd, prot_hit, cmd_start, cmd_complete} = '0;
        {cmd_violation, rst_seq_done, rst_seq_dfault, rd_valid, rd_dbl_fault} = '0;
        {rd_sgl_fault, rd_invalid_busy, htrans, cmd_error, rst_seq_error, hsize, haddr} = '0;
        hwdata = '0;
        @(posedge mclk);
        boot(2'h2, 1'b1);
        rd_chk("status", FSF_STATUS_OFS, 8'h82);
        rd_chk("error", FSF_ERROR_OFS, 8'h02);
        boot(2'h0, 1'b0);
        rd_chk("status", FSF_STATUS_OFS, 8'h80);
        rd_chk("error", FSF_ERROR_OFS, 8'h00);
        rd_chk("ctrl", FSF_CTRL_OFS, 8'h00);
        $display("test reset done");
        wr(FSF_STATUS_OFS, 8'h00);
        check("launch", 32'(launched), 32'h0);
        wr(FSF_STATUS_OFS, 8'h80);
        check("launch", 32'(launched), 32'h1);
        rd_chk("status", FSF_STATUS_OFS, 8'h00);
        ev(8'h10);
        rd_chk("status", FSF_STATUS_OFS, 8'h08);
        cmd_error <= 2'h1;
        @(posedge mclk);
        rd_chk("status", FSF_STATUS_OFS, 8'h09);
        cmd_error <= 2'h0;
        ev(8'h08);
        rd_chk("status", FSF_STATUS_OFS, 8'h81);
        wr(FSF_STATUS_OFS, 8'h7F);
        rd_chk("status", FSF_STATUS_OFS, 8'h81);
        wr(FSF_STATUS_OFS, 8'h80);
        ev(8'h10);
        rd_chk("status", FSF_STATUS_OFS, 8'h08);
        ev(8'h04);
        rd_chk("status", FSF_STATUS_OFS, 8'h80);
        $display("test launch done");
        for (int i = 0; i < 2; i++) begin
            ev(i == 0 ? 8'h80 : 8'h40);
            rd_chk("status", FSF_STATUS_OFS, 8'hA0);
            wr(FSF_STATUS_OFS, 8'h80);
            check("launch", 32'(launched), 32'h0);
            rd_chk("status", FSF_STATUS_OFS, 8'hA0);
            wr(FSF_STATUS_OFS, 8'h00);
            rd_chk("status", FSF_STATUS_OFS, 8'hA0);
            wr(FSF_STATUS_OFS, 8'h20);
            rd_chk("status", FSF_STATUS_OFS, 8'h80);
        end
        ev(8'h20);
        rd_chk("status", FSF_STATUS_OFS, 8'h90);
        check("allow", 32'(seq_start_allow), 32'h0);
        wr(FSF_STATUS_OFS, 8'h80);
        check("launch", 32'(launched), 32'h0);
        wr(FSF_STATUS_OFS, 8'h00);
        rd_chk("status", FSF_STATUS_OFS, 8'h90);
        wr(FSF_STATUS_OFS, 8'h10);
        rd_chk("status", FSF_STATUS_OFS, 8'h80);
        check("allow", 32'(seq_start_allow), 32'h1);
        $display("test errors done");
        for (int i = 0; i < 3; i++) begin
            {rd_dbl_fault, rd_sgl_fault, rd_invalid_busy} <= fq[i];
            ev(8'h01);
            rd_chk("error", FSF_ERROR_OFS, fx[i]);
            wr(FSF_ERROR_OFS, 8'h00);
            rd_chk("error", FSF_ERROR_OFS, fx[i]);
            wr(FSF_ERROR_OFS, fx[i]);
            rd_chk("error", FSF_ERROR_OFS, 8'h00);
        end
        $display("test faults done");
        wr(FSF_CTRL_OFS, 8'h91);
        rd_chk("ctrl", FSF_CTRL_OFS, 8'h91);
        check("ignore", 32'(ignore_single_fault), 32'h1);
        check("done_irq", 32'(cmd_done_irq), 32'h1);
        {rd_dbl_fault, rd_sgl_fault, rd_invalid_busy} <= 3'h2;
        ev(8'h01);
        rd_chk("error", FSF_ERROR_OFS, 8'h00);
        check("sf_irq", 32'(single_fault_irq), 32'h0);
        wr(FSF_CTRL_OFS, 8'h81);
        ev(8'h01);
        rd_chk("error", FSF_ERROR_OFS, 8'h01);
        check("sf_irq", 32'(single_fault_irq), 32'h1);
        wr(FSF_STATUS_OFS, 8'h80);
        repeat (2) @(posedge mclk);
        check("done_irq", 32'(cmd_done_irq), 32'h0);
        ev(8'h08);
        @(posedge mclk);
        check("done_irq", 32'(cmd_done_irq), 32'h1);
        wr(8'h0C, 8'hFF);
        rd_chk("unmapped", 8'h0C, 8'h00);
        rd_chk("status", FSF_STATUS_OFS, 8'h80);
        $display("test irq done");
        summarize();
    end
endmodule
